// [logic/irsd_decoder.sv]
// module: i/o register space decoder and local register bank
`timescale 1ns/1ns
module irsd_decoder (
	input wire logic clock,
	input wire logic rst_b,
	input irsd_pkg::irsd_req_t req,
	input wire logic [7:0] pin_b,
	input wire logic [7:0] pin_c,
	input wire logic [7:0] pin_d,
	input wire logic [7:0] tmr0_evt,
	input wire logic [7:0] tmr1_evt,
	input wire logic [7:0] tmr2_evt,
	input wire logic [7:0] pcg_evt,
	output irsd_pkg::irsd_resp_t resp_reg,
	output irsd_pkg::irsd_port_t port_b_reg,
	output irsd_pkg::irsd_port_t port_c_reg,
	output irsd_pkg::irsd_port_t port_d_reg,
	output logic [7:0] timer0_flags,
	output logic [7:0] timer1_flags,
	output logic [7:0] timer2_flags,
	output logic [7:0] pcg_flags,
	output logic [7:0] scratch0_reg,
	output logic [7:0] nvs_ctrl_reg
);

	// ==========================================================
	// helpers
	function automatic logic is_io_op(input irsd_pkg::irsd_op_t op);
		is_io_op = (op != irsd_pkg::IRSD_OP_DATA_LOAD) && (op != irsd_pkg::IRSD_OP_DATA_STORE);
	endfunction

	function automatic logic is_bit_op(input irsd_pkg::irsd_op_t op);
		is_bit_op = (op == irsd_pkg::IRSD_OP_BIT_SET) || (op == irsd_pkg::IRSD_OP_BIT_CLEAR) ||
			(op == irsd_pkg::IRSD_OP_SKIP_ONE) || (op == irsd_pkg::IRSD_OP_SKIP_ZERO);
	endfunction

	function automatic logic is_write_op(input irsd_pkg::irsd_op_t op);
		is_write_op = (op == irsd_pkg::IRSD_OP_IO_WRITE) || (op == irsd_pkg::IRSD_OP_DATA_STORE) ||
			(op == irsd_pkg::IRSD_OP_BIT_SET) || (op == irsd_pkg::IRSD_OP_BIT_CLEAR);
	endfunction

	function automatic logic [7:0] onehot(input logic [2:0] b);
		onehot = 8'h01 << b;
	endfunction

	// new value of a plain read/write register; bit ops touch one bit only
	function automatic logic [7:0] rw_update(input logic [7:0] old, input irsd_pkg::irsd_op_t op,
		input logic [2:0] b, input logic [7:0] wd, input logic [7:0] mask);
		case (op)
			irsd_pkg::IRSD_OP_BIT_SET: rw_update = (old | onehot(b)) & mask;
			irsd_pkg::IRSD_OP_BIT_CLEAR: rw_update = old & ~onehot(b) & mask;
			default: rw_update = wd & mask;
		endcase
	endfunction

	// ==========================================================
	// decode
	logic [7:0] data_addr;
	logic [7:0] io_idx;
	logic local_hit;
	logic local_mapped;
	logic mem_hit;
	logic refused;
	logic wr_ok;
	logic mem_wr_en;
	logic [7:0] mem_idx;
	logic [7:0] local_rd;
	logic [7:0] w1c_mask;
	logic [7:0] pb_lvl_reg;
	logic [7:0] pc_lvl_reg;
	logic [7:0] pd_lvl_reg;

	// map port addresses into data space, then classify the target
	always_comb begin
		data_addr = is_io_op(req.op) ? 8'(req.addr + irsd_pkg::IO_TO_DATA_OFS) : req.addr;
		io_idx = 8'(data_addr - irsd_pkg::IO_TO_DATA_OFS);
		local_hit = (data_addr >= irsd_pkg::IO_TO_DATA_OFS) && (data_addr < irsd_pkg::MEM_FIRST);
		mem_hit = data_addr >= irsd_pkg::MEM_FIRST; // extended part is reached by loads/stores only
		mem_idx = 8'(data_addr - irsd_pkg::MEM_FIRST);
		refused = 1'b0;
		if (is_io_op(req.op) && (req.addr > irsd_pkg::IO_LAST)) begin
			refused = 1'b1;
		end
		if (is_bit_op(req.op) && (req.addr > irsd_pkg::BIT_IO_LAST)) begin
			refused = 1'b1;
		end
		if (!is_io_op(req.op) && (data_addr < irsd_pkg::IO_TO_DATA_OFS)) begin
			refused = 1'b1;
		end
		if (is_write_op(req.op) && local_hit && !local_mapped) begin
			refused = 1'b1;
		end
		if (is_write_op(req.op) && mem_hit && !irsd_pkg::mem_implemented(data_addr)) begin
			refused = 1'b1;
		end
		wr_ok = req.valid && is_write_op(req.op) && !refused;
		mem_wr_en = wr_ok && mem_hit;
	end

	// local read mux; reserved locations and bits read zero
	always_comb begin
		local_mapped = 1'b1;
		case (io_idx)
			irsd_pkg::OFS_PB_PIN: local_rd = pb_lvl_reg;
			irsd_pkg::OFS_PB_DIR: local_rd = port_b_reg.dir;
			irsd_pkg::OFS_PB_OUT: local_rd = port_b_reg.out;
			irsd_pkg::OFS_PC_PIN: local_rd = pc_lvl_reg;
			irsd_pkg::OFS_PC_DIR: local_rd = port_c_reg.dir;
			irsd_pkg::OFS_PC_OUT: local_rd = port_c_reg.out;
			irsd_pkg::OFS_PD_PIN: local_rd = pd_lvl_reg;
			irsd_pkg::OFS_PD_DIR: local_rd = port_d_reg.dir;
			irsd_pkg::OFS_PD_OUT: local_rd = port_d_reg.out;
			irsd_pkg::OFS_TMR0_FLAGS: local_rd = timer0_flags;
			irsd_pkg::OFS_TMR1_FLAGS: local_rd = timer1_flags;
			irsd_pkg::OFS_TMR2_FLAGS: local_rd = timer2_flags;
			irsd_pkg::OFS_PCG_FLAGS: local_rd = pcg_flags;
			irsd_pkg::OFS_SCRATCH0: local_rd = scratch0_reg;
			irsd_pkg::OFS_NVS_CTRL: local_rd = nvs_ctrl_reg;
			default: begin
				local_rd = irsd_pkg::RST_ZERO;
				local_mapped = 1'b0;
			end
		endcase
	end

	// ones written to a flag register: whole byte, or the single addressed bit
	always_comb begin
		case (req.op)
			irsd_pkg::IRSD_OP_BIT_SET: w1c_mask = onehot(req.bit_sel);
			irsd_pkg::IRSD_OP_IO_WRITE, irsd_pkg::IRSD_OP_DATA_STORE: w1c_mask = req.wdata;
			default: w1c_mask = irsd_pkg::RST_ZERO;
		endcase
	end

	// ==========================================================
	// pin level sampling

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pb_lvl_reg <= irsd_pkg::RST_ZERO;
			pc_lvl_reg <= irsd_pkg::RST_ZERO;
			pd_lvl_reg <= irsd_pkg::RST_ZERO;
		end else begin
			pb_lvl_reg <= pin_b;
			pc_lvl_reg <= pin_c & irsd_pkg::MASK_PORT_C;
			pd_lvl_reg <= pin_d;
		end
	end

	// ==========================================================
	// read/write registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			port_b_reg <= '0;
			port_c_reg <= '0;
			port_d_reg <= '0;
			scratch0_reg <= irsd_pkg::RST_ZERO;
			nvs_ctrl_reg <= irsd_pkg::RST_ZERO;
		end else if (wr_ok && local_hit) begin
			case (io_idx)
				irsd_pkg::OFS_PB_DIR: port_b_reg.dir <= rw_update(port_b_reg.dir, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_FULL);
				irsd_pkg::OFS_PB_OUT: port_b_reg.out <= rw_update(port_b_reg.out, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_FULL);
				irsd_pkg::OFS_PC_DIR: port_c_reg.dir <= rw_update(port_c_reg.dir, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_PORT_C);
				irsd_pkg::OFS_PC_OUT: port_c_reg.out <= rw_update(port_c_reg.out, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_PORT_C);
				irsd_pkg::OFS_PD_DIR: port_d_reg.dir <= rw_update(port_d_reg.dir, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_FULL);
				irsd_pkg::OFS_PD_OUT: port_d_reg.out <= rw_update(port_d_reg.out, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_FULL);
				irsd_pkg::OFS_SCRATCH0: scratch0_reg <= rw_update(scratch0_reg, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_FULL);
				irsd_pkg::OFS_NVS_CTRL: nvs_ctrl_reg <= rw_update(nvs_ctrl_reg, req.op,
					req.bit_sel, req.wdata, irsd_pkg::MASK_NVS_CTRL);
				default: scratch0_reg <= scratch0_reg; // pin levels and flags handled elsewhere
			endcase
		end
	end

	// ==========================================================
	// status flag registers
	logic flag_wr;
	assign flag_wr = wr_ok && local_hit;

	irsd_w1c_flags #(.W(8), .IMPL(irsd_pkg::MASK_TMR0)) u_tmr0 (
		.clock(clock),
		.rst_b(rst_b),
		.set_pulse(tmr0_evt),
		.clr_mask((flag_wr && io_idx == irsd_pkg::OFS_TMR0_FLAGS) ? w1c_mask : irsd_pkg::RST_ZERO),
		.flags_reg(timer0_flags)
	);

	irsd_w1c_flags #(.W(8), .IMPL(irsd_pkg::MASK_TMR1)) u_tmr1 (
		.clock(clock),
		.rst_b(rst_b),
		.set_pulse(tmr1_evt),
		.clr_mask((flag_wr && io_idx == irsd_pkg::OFS_TMR1_FLAGS) ? w1c_mask : irsd_pkg::RST_ZERO),
		.flags_reg(timer1_flags)
	);

	irsd_w1c_flags #(.W(8), .IMPL(irsd_pkg::MASK_TMR2)) u_tmr2 (
		.clock(clock),
		.rst_b(rst_b),
		.set_pulse(tmr2_evt),
		.clr_mask((flag_wr && io_idx == irsd_pkg::OFS_TMR2_FLAGS) ? w1c_mask : irsd_pkg::RST_ZERO),
		.flags_reg(timer2_flags)
	);

	irsd_w1c_flags #(.W(8), .IMPL(irsd_pkg::MASK_PCG)) u_pcg (
		.clock(clock),
		.rst_b(rst_b),
		.set_pulse(pcg_evt),
		.clr_mask((flag_wr && io_idx == irsd_pkg::OFS_PCG_FLAGS) ? w1c_mask : irsd_pkg::RST_ZERO),
		.flags_reg(pcg_flags)
	);

	// ==========================================================
	// upper i/o and extended store
	logic [7:0] mem_q;

	irsd_reg_store #(.DEPTH(irsd_pkg::MEM_DEPTH), .AW(8), .DW(8)) u_store (
		.clock(clock),
		.rst_b(rst_b),
		.wr_en(mem_wr_en),
		.wr_addr(mem_idx),
		.wr_data(req.wdata),
		.rd_addr(mem_idx),
		.rd_data(mem_q)
	);

	// ==========================================================
	// answer pipeline: stage one captures the access
	logic s1_valid;
	logic s1_refused;
	logic s1_from_mem;
	logic s1_zero;
	irsd_pkg::irsd_op_t s1_op;
	logic [2:0] s1_bit;
	logic [7:0] s1_lrd;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s1_valid <= 1'b0;
			s1_refused <= 1'b0;
			s1_from_mem <= 1'b0;
			s1_zero <= 1'b0;
			s1_op <= irsd_pkg::IRSD_OP_IO_READ;
			s1_bit <= 3'h0;
			s1_lrd <= irsd_pkg::RST_ZERO;
		end else begin
			s1_valid <= req.valid;
			s1_refused <= req.valid && refused;
			s1_from_mem <= mem_hit;
			s1_zero <= refused || (mem_hit && !irsd_pkg::mem_implemented(data_addr));
			s1_op <= req.op;
			s1_bit <= req.bit_sel;
			s1_lrd <= local_rd;
		end
	end

	// stage two: read data and skip decision
	logic [7:0] s2_rd;
	always_comb begin
		s2_rd = s1_zero ? irsd_pkg::RST_ZERO : (s1_from_mem ? mem_q : s1_lrd);
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			resp_reg <= '0;
		end else begin
			resp_reg.valid <= s1_valid;
			resp_reg.refused <= s1_refused;
			resp_reg.rdata <= s1_valid ? s2_rd : irsd_pkg::RST_ZERO;
			resp_reg.skip <= s1_valid && !s1_refused &&
				(((s1_op == irsd_pkg::IRSD_OP_SKIP_ONE) && s2_rd[s1_bit]) ||
				((s1_op == irsd_pkg::IRSD_OP_SKIP_ZERO) && !s2_rd[s1_bit]));
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	irsd_pkg::irsd_req_t req_q;
	logic exp_skip;
	always_ff @(posedge clock) begin
		req_q <= req;
	end
	assign exp_skip = port_b_reg.out[req.bit_sel];

	property p_bit_range;
		req.valid && is_bit_op(req.op) && req.addr > irsd_pkg::BIT_IO_LAST |-> ##2 resp_reg.refused;
	endproperty
	a_bit_range: assert property (p_bit_range) else $error("high bit op not refused");

	property p_skip_one;
		req.valid && req.op == irsd_pkg::IRSD_OP_SKIP_ONE && req.addr == irsd_pkg::OFS_PB_OUT
			|-> ##2 resp_reg.skip == $past(exp_skip, 2);
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("skip result wrong");

	property p_w1c_clear;
		req.valid && req.op == irsd_pkg::IRSD_OP_IO_WRITE && req.addr == irsd_pkg::OFS_TMR1_FLAGS
			&& tmr1_evt == 8'h00 |=> (timer1_flags & req_q.wdata) == 8'h00;
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared");

	property p_w0_keep;
		req.valid && req.op == irsd_pkg::IRSD_OP_DATA_STORE &&
			req.addr == 8'(irsd_pkg::OFS_TMR1_FLAGS + irsd_pkg::IO_TO_DATA_OFS)
			&& req.wdata == 8'h00 && tmr1_evt == 8'h00 |=> timer1_flags == $past(timer1_flags);
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("zero write changed flag");

	property p_bit_only;
		req.valid && req.op == irsd_pkg::IRSD_OP_BIT_SET && req.addr == irsd_pkg::OFS_TMR1_FLAGS
			&& tmr1_evt == 8'h00 |=> (timer1_flags | onehot(req_q.bit_sel)) ==
			($past(timer1_flags) | onehot(req_q.bit_sel));
	endproperty
	a_bit_only: assert property (p_bit_only) else $error("neighbour flag disturbed");

	property p_data_alias;
		req.valid && req.op == irsd_pkg::IRSD_OP_DATA_STORE &&
			req.addr == 8'(irsd_pkg::OFS_PB_DIR + irsd_pkg::IO_TO_DATA_OFS)
			|=> port_b_reg.dir == req_q.wdata;
	endproperty
	a_data_alias: assert property (p_data_alias) else $error("data alias missed");

	property p_io_range;
		req.valid && is_io_op(req.op) && req.addr > irsd_pkg::IO_LAST |-> ##2 resp_reg.refused;
	endproperty
	a_io_range: assert property (p_io_range) else $error("port op above range taken");

	property p_ext_only_data;
		mem_wr_en && data_addr >= irsd_pkg::EXT_FIRST |-> req.op == irsd_pkg::IRSD_OP_DATA_STORE;
	endproperty
	a_ext_only_data: assert property (p_ext_only_data) else $error("ext reached by port op");

	property p_rsv_read;
		req.valid && req.op == irsd_pkg::IRSD_OP_DATA_LOAD && req.addr == 8'h63
			|-> ##2 resp_reg.rdata == 8'h00 && !resp_reg.refused;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved read not zero");

	property p_rsv_write;
		req.valid && req.op == irsd_pkg::IRSD_OP_DATA_STORE && req.addr == 8'h63
			|-> !mem_wr_en ##2 resp_reg.refused;
	endproperty
	a_rsv_write: assert property (p_rsv_write) else $error("reserved write taken");

	c_skip_taken: cover property (req.valid && req.op == irsd_pkg::IRSD_OP_SKIP_ONE ##2 resp_reg.skip);
	c_flag_clear: cover property (timer1_flags != 8'h00 ##1 timer1_flags == 8'h00);
	c_ext_store: cover property (mem_wr_en && data_addr >= irsd_pkg::EXT_FIRST);
	c_refused: cover property (resp_reg.refused);

endmodule

// [shared/irsd_pkg.sv]
// package: constants, types and helpers for the i/o register space decoder
package irsd_pkg;

	// ==========================================================
	// address space layout
	localparam logic [7:0] IO_TO_DATA_OFS = 8'h20; // data address = i/o address + this
	localparam logic [7:0] BIT_IO_LAST = 8'h1f; // last bit-accessible i/o address
	localparam logic [7:0] IO_LAST = 8'h3f; // last i/o address of port instructions
	localparam logic [7:0] EXT_FIRST = 8'h60; // first extended data address
	localparam logic [7:0] EXT_LAST = 8'hff; // last extended data address
	localparam logic [7:0] MEM_FIRST = 8'h40; // first data address backed by the store
	localparam int IO_LOCATIONS = 64; // locations reachable by port instructions
	localparam int MEM_DEPTH = 192; // data 0x40..0xff

	// ==========================================================
	// i/o offsets of the local registers
	localparam logic [7:0] OFS_PB_PIN = 8'h03;
	localparam logic [7:0] OFS_PB_DIR = 8'h04;
	localparam logic [7:0] OFS_PB_OUT = 8'h05;
	localparam logic [7:0] OFS_PC_PIN = 8'h06;
	localparam logic [7:0] OFS_PC_DIR = 8'h07;
	localparam logic [7:0] OFS_PC_OUT = 8'h08;
	localparam logic [7:0] OFS_PD_PIN = 8'h09;
	localparam logic [7:0] OFS_PD_DIR = 8'h0a;
	localparam logic [7:0] OFS_PD_OUT = 8'h0b;
	localparam logic [7:0] OFS_TMR0_FLAGS = 8'h15;
	localparam logic [7:0] OFS_TMR1_FLAGS = 8'h16;
	localparam logic [7:0] OFS_TMR2_FLAGS = 8'h17;
	localparam logic [7:0] OFS_PCG_FLAGS = 8'h1b;
	localparam logic [7:0] OFS_SCRATCH0 = 8'h1e;
	localparam logic [7:0] OFS_NVS_CTRL = 8'h1f;

	// ==========================================================
	// implemented-bit masks and reset values
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_PORT_C = 8'h7f;
	localparam logic [7:0] MASK_TMR0 = 8'h07;
	localparam logic [7:0] MASK_TMR1 = 8'h27;
	localparam logic [7:0] MASK_TMR2 = 8'h07;
	localparam logic [7:0] MASK_PCG = 8'h07;
	localparam logic [7:0] MASK_NVS_CTRL = 8'h3f;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// ==========================================================
	// access kinds issued by the core
	typedef enum logic [2:0] {
		IRSD_OP_IO_READ = 3'b000, // port read
		IRSD_OP_IO_WRITE = 3'b001, // port write
		IRSD_OP_BIT_SET = 3'b010, // set_io_bit_instr
		IRSD_OP_BIT_CLEAR = 3'b011, // clear_io_bit_instr
		IRSD_OP_SKIP_ONE = 3'b100, // skip_if_io_bit_one
		IRSD_OP_SKIP_ZERO = 3'b101, // skip_if_io_bit_zero
		IRSD_OP_DATA_LOAD = 3'b110, // indirect/direct/displaced load
		IRSD_OP_DATA_STORE = 3'b111 // indirect/direct/displaced store
	} irsd_op_t;

	typedef struct packed {
		logic valid;
		irsd_op_t op;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} irsd_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] rdata;
		logic skip;
		logic refused;
	} irsd_resp_t;

	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] out;
	} irsd_port_t;

	// ==========================================================
	// implemented data addresses in 0x40..0xff; all others are reserved
	function automatic logic mem_implemented(input logic [7:0] a);
		case (a) inside
			[8'h40:8'h48], [8'h4a:8'h4e], 8'h50, [8'h53:8'h55], 8'h57,
			[8'h5d:8'h5f], 8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h69,
			[8'h6b:8'h70], [8'h78:8'h7c], [8'h7e:8'h82], [8'h84:8'h8b],
			[8'hb0:8'hb4], 8'hb6, [8'hb8:8'hbd], [8'hc0:8'hc2],
			[8'hc4:8'hc6]: mem_implemented = 1'b1;
			default: mem_implemented = 1'b0;
		endcase
	endfunction

endpackage

// [logic/irsd_w1c_flags.sv]
// module: one status flag register, hardware sets, software writes one to clear
`timescale 1ns/1ns
module irsd_w1c_flags #(
	parameter int W = 8,
	parameter logic [7:0] IMPL = 8'hff
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [W-1:0] set_pulse,
	input wire logic [W-1:0] clr_mask,
	output logic [W-1:0] flags_reg
);

	// ==========================================================
	// flag state: a set in the clearing cycle wins
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= ((flags_reg & ~clr_mask) | set_pulse) & IMPL[W-1:0];
		end
	end

	// ==========================================================
	// checks
	property p_set_wins;
		@(posedge clock) disable iff (!rst_b)
		(set_pulse & IMPL[W-1:0]) != '0 |=>
			(flags_reg & $past(set_pulse) & IMPL[W-1:0]) == ($past(set_pulse) & IMPL[W-1:0]);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag set lost");

endmodule

// [logic/irsd_reg_store.sv]
// module: byte store behind the upper i/o and extended register locations
`timescale 1ns/1ns
module irsd_reg_store #(
	parameter int DEPTH = 192,
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);

	logic [DW-1:0] mem [DEPTH];

	// ==========================================================
	// write port
	always_ff @(posedge clock) begin
		if (wr_en && (int'(wr_addr) < DEPTH)) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// ==========================================================
	// registered read port
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rd_data <= '0;
		end else if (int'(rd_addr) < DEPTH) begin
			rd_data <= mem[rd_addr];
		end else begin
			rd_data <= '0;
		end
	end

endmodule

// [sim/irsd_core_model.sv]
// partner model: processor core issuing i/o and data-space accesses
`timescale 1ns/1ns
module irsd_core_model (
	input wire logic clock,
	output irsd_pkg::irsd_req_t req,
	input irsd_pkg::irsd_resp_t resp
);
	// ==========================================================
	// request driver
	initial begin
		req = '0;
	end

	// one access per call, then a bounded wait for the answer
	task automatic access(input irsd_pkg::irsd_op_t op, input logic [7:0] addr,
		input logic [2:0] bsel, input logic [7:0] wd, output irsd_pkg::irsd_resp_t r,
		output logic ok);
		ok = 1'b0;
		r = '0;
		@(negedge clock);
		req <= '{1'b1, op, addr, bsel, wd};
		@(negedge clock);
		// released address, bit and data fields are inverted so a stale value never looks held
		req <= '{1'b0, op, ~addr, ~bsel, ~wd};
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge clock);
			if (resp.valid === 1'b1) begin
				r = resp;
				ok = 1'b1;
			end
		end
	endtask
endmodule

// [sim/tb.sv]
// testbench: register space accesses through the core model
`timescale 1ns/1ns
module tb;
	localparam irsd_pkg::irsd_op_t RD = irsd_pkg::IRSD_OP_IO_READ;
	localparam irsd_pkg::irsd_op_t WR = irsd_pkg::IRSD_OP_IO_WRITE;
	localparam irsd_pkg::irsd_op_t BS = irsd_pkg::IRSD_OP_BIT_SET;
	localparam irsd_pkg::irsd_op_t BC = irsd_pkg::IRSD_OP_BIT_CLEAR;
	localparam irsd_pkg::irsd_op_t SO = irsd_pkg::IRSD_OP_SKIP_ONE;
	localparam irsd_pkg::irsd_op_t SZ = irsd_pkg::IRSD_OP_SKIP_ZERO;
	localparam irsd_pkg::irsd_op_t LD = irsd_pkg::IRSD_OP_DATA_LOAD;
	localparam irsd_pkg::irsd_op_t ST = irsd_pkg::IRSD_OP_DATA_STORE;
	logic clock;
	logic rst_b;
	logic ok;
	irsd_pkg::irsd_req_t req;
	irsd_pkg::irsd_resp_t resp_reg;
	irsd_pkg::irsd_resp_t r;
	localparam logic [7:0] OUT_PAT = 8'he4;
	irsd_pkg::irsd_port_t pb;
	irsd_pkg::irsd_port_t pc;
	irsd_pkg::irsd_port_t pd;
	logic [7:0] sc;
	logic [7:0] nv;
	logic [7:0] pin_b, pin_c, pin_d;
	logic [7:0] t0, t1, t2, pg;
	logic [7:0] f0, f1, f2, fp;
	int n_fail;
	int tests_run;

	irsd_core_model i_core (.clock(clock), .req(req), .resp(resp_reg));

	irsd_decoder i_dut (.clock(clock), .rst_b(rst_b), .req(req), .pin_b(pin_b),
		.pin_c(pin_c), .pin_d(pin_d), .tmr0_evt(t0), .tmr1_evt(t1), .tmr2_evt(t2),
		.pcg_evt(pg), .resp_reg(resp_reg), .port_b_reg(pb), .port_c_reg(pc),
		.port_d_reg(pd), .timer0_flags(f0), .timer1_flags(f1), .timer2_flags(f2),
		.pcg_flags(fp), .scratch0_reg(sc), .nvs_ctrl_reg(nv));

	// ==========================================================
	// clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ==========================================================
	// compare, access and closing tasks
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic go(input irsd_pkg::irsd_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] wd);
		i_core.access(op, a, b, wd, r, ok);
		if (ok !== 1'b1) begin
			n_fail++;
			$display("BAD answer expected 1 seen 0");
			give_verdict();
		end
	endtask

	// access that must be answered with a byte and not refused
	task automatic rdc(input irsd_pkg::irsd_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] e);
		go(op, a, b, 8'h00);
		chk_byte("rdata", e, r.rdata);
		chk_bit("refused", 1'b0, r.refused);
	endtask

	// access that must be refused with zero data
	task automatic refc(input irsd_pkg::irsd_op_t op, input logic [7:0] a);
		go(op, a, 3'h0, 8'hff);
		chk_bit("refused", 1'b1, r.refused);
		chk_byte("rdata", 8'h00, r.rdata);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		n_fail = 0;
		tests_run = 0;
		rst_b = 1'b0;
		{pin_b, pin_c, pin_d} = {8'h5a, 8'hff, 8'h3c};
		{t0, t1, t2, pg} = '0;
		repeat (16) @(negedge clock);
		rst_b = 1'b1;
		rdc(RD, 8'h05, 3'h0, 8'h00);
		chk_byte("tmr1 flags", 8'h00, f1);
		$display("test reset done");

		go(WR, 8'h05, 3'h0, 8'ha5);
		chk_byte("old data", 8'h00, r.rdata);
		rdc(LD, 8'h25, 3'h0, 8'ha5);
		go(ST, 8'h24, 3'h0, 8'h3c);
		rdc(RD, 8'h04, 3'h0, 8'h3c);
		rdc(RD, 8'h06, 3'h0, 8'h7f);
		go(WR, 8'h03, 3'h0, 8'hff);
		rdc(RD, 8'h03, 3'h0, 8'h5a);
		rdc(RD, 8'h09, 3'h0, 8'h3c);
		go(WR, 8'h08, 3'h0, 8'h55);
		go(ST, 8'h2a, 3'h0, 8'h99);
		go(BS, 8'h1e, 3'h7, 8'h00);
		go(WR, 8'h1f, 3'h0, 8'h2a);
		go(BC, 8'h1f, 3'h1, 8'h00);
		chk_byte("port c out", 8'h55, pc.out);
		chk_byte("port d dir", 8'h99, pd.dir);
		chk_byte("scratch", 8'h80, sc);
		chk_byte("nvs ctrl", 8'h28, nv);
		$display("test mapping done");

		go(BC, 8'h05, 3'h0, 8'h00);
		go(BS, 8'h05, 3'h6, 8'h00);
		rdc(RD, 8'h05, 3'h0, 8'he4);
		chk_byte("port b out", 8'he4, pb.out);
		for (int b = 0; b < 8; b++) begin
			go(SO, 8'h05, b[2:0], 8'h00);
			chk_bit("skip one", OUT_PAT[b], r.skip);
			go(SZ, 8'h05, b[2:0], 8'h00);
			chk_bit("skip zero", !OUT_PAT[b], r.skip);
		end
		go(ST, 8'h40, 3'h0, 8'h00);
		refc(BS, 8'h20);
		rdc(LD, 8'h40, 3'h0, 8'h00);
		refc(SZ, 8'h20);
		$display("test bit access done");

		@(negedge clock);
		{t0, t1, t2, pg} = '1;
		@(negedge clock);
		{t0, t1, t2, pg} = '0;
		chk_byte("tmr1 flags", 8'h27, f1);
		go(WR, 8'h16, 3'h0, 8'h01);
		chk_byte("tmr1 flags", 8'h26, f1);
		go(ST, 8'h36, 3'h0, 8'h00);
		chk_byte("tmr1 flags", 8'h26, f1);
		go(BS, 8'h16, 3'h1, 8'h00);
		chk_byte("tmr1 flags", 8'h24, f1);
		go(BC, 8'h16, 3'h2, 8'h00);
		chk_byte("tmr1 flags", 8'h24, f1);
		go(ST, 8'h35, 3'h0, 8'h05);
		chk_byte("tmr0 flags", 8'h02, f0);
		go(WR, 8'h1b, 3'h0, 8'h06);
		chk_byte("pcg flags", 8'h01, fp);
		chk_byte("tmr2 flags", 8'h07, f2);
		$display("test flags done");

		go(WR, 8'h3f, 3'h0, 8'h81);
		rdc(LD, 8'h5f, 3'h0, 8'h81);
		refc(RD, 8'h40);
		refc(WR, 8'h40);
		go(ST, 8'h60, 3'h0, 8'h55);
		rdc(LD, 8'h60, 3'h0, 8'h55);
		refc(RD, 8'h60);
		refc(LD, 8'h1f);
		rdc(RD, 8'h00, 3'h0, 8'h00);
		refc(WR, 8'h00);
		refc(ST, 8'h63);
		rdc(LD, 8'h63, 3'h0, 8'h00);
		$display("test ranges done");
		give_verdict();
	end
endmodule
